// [verilog/tcc_top.sv]
// two-channel timer capture/compare block with apb register access
// assumes the shared counter, prescaler and modulo logic sit outside on clk,
// giving counter_value and a one-cycle counter_overflow pulse per period
// Functional notes
// - both edge/level bits zero: channel detached, pin left to general-purpose I/O
// - reset clears both edge/level bits of every channel
// - edge bits pick capture edge, or compare output action
// - decode: 01 rise, 10 fall, 11 both; compare 00 none, toggle, clear, set
// - channel 1 has no pin; its output and toggle reach nothing
// - compare mode with toggle-on-overflow inverts output at each overflow, except clear-on-compare with max duty (held high)
// - toggle-on-overflow ignored in capture; reset clears it
// - overflow action wins over a simultaneous compare match
// - toggle plus clear-on-compare plus max duty holds output high
// - max duty changes apply from the period after the write
// - clear-on-compare, no toggle, no max duty: output stays low
// - value register takes captured count or holds compare value
// - capture: reading high byte blocks captures until low byte read
// - compare: writing high byte blocks matches until low byte written
// - flag sets on event; cleared by read-with-flag then write 0
// - channel 0 buffered mode disables channel 1 control register
// - overflow pulse from the shared counter drives toggle and max duty
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
module tcc_top
    import tcc_pkg::*;
#(
    parameter int CNT_W = tcc_pkg::TCC_CNT_W
)
(
    input  wire logic                         clk,
    input  wire logic                         reset,
    input  wire logic                         ce,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [tcc_pkg::TCC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]                  pwdata,
    output logic [31:0]                       prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic [CNT_W-1:0]             counter_value,
    input  wire logic                         counter_overflow,
    input  wire logic                         channel0_port_pin_in,
    output logic                              channel0_port_pin_out,
    output logic                              channel0_port_pin_oe,
    output logic [tcc_pkg::TCC_NUM_CH-1:0]    channel_irq
);
    import tcc_pkg::*;
    localparam int NC = TCC_NUM_CH;
    localparam int BW = TCC_BYTE_W;

    // apb and output flops
    logic             pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0]      prdata_q, prdata_d;
    logic             pin_out_q, pin_out_d, pin_oe_q, pin_oe_d;
    logic [NC-1:0]    irq_q, irq_d;
    // pin synchroniser
    logic [2:0]       sync_q, sync_d;
    logic             stable_q, stable_d;
    // channel state
    logic [NC-1:0]    ie_q, ie_d, buf_q, buf_d, cmp_q, cmp_d, elh_q, elh_d, ell_q, ell_d;
    logic [NC-1:0]    tov_q, tov_d, max_q, max_d, flag_q, flag_d, arm_q, arm_d;
    logic [NC-1:0]    capblk_q, capblk_d, cmpblk_q, cmpblk_d;
    logic [CNT_W-1:0] value_q [NC], value_d [NC];
    logic             sel_q, sel_d, swap_q, swap_d;
    // decode and channel wires
    logic [3:0]       dec;
    logic             done, wr, rd;
    logic [NC-1:0]    cap_ev, cmp_ev, ch_out, ch_drive, ch_en;
    logic [CNT_W-1:0] cmp_val [NC];
    logic [NC-1:0]    cmp_inh;
    logic [BW-1:0]    rbyte;

    always_comb
    begin
        dec = tcc_decode_addr(paddr[TCC_ADDR_W-1:0]);
        done = psel && penable && pready_q;
        wr = done && pwrite && dec[3] && !pslverr_q;
        rd = done && !pwrite && dec[3] && !pslverr_q;
    end

    // channel 1 detaches while channel 0 runs buffered: its value word is the spare buffer
    assign ch_en[0] = 1'b1;
    assign ch_en[1] = !buf_q[0];

    assign cmp_val[0] = buf_q[0] ? value_q[sel_q] : value_q[0];
    assign cmp_inh[0] = buf_q[0] ? cmpblk_q[sel_q] : cmpblk_q[0];
    assign cmp_val[1] = value_q[1];
    assign cmp_inh[1] = cmpblk_q[1];

    genvar gi;
    generate
        for (gi = 0; gi < NC; gi++)
        begin : g_ch
            tcc_channel #(
                .CNT_W (CNT_W)
            ) u_ch (
                .clk             (clk),
                .reset           (reset),
                .ce              (ce),
                .buf_sel         (buf_q[gi] && ch_en[gi]),
                .cmp_sel         (cmp_q[gi] && ch_en[gi]),
                .els             ({elh_q[gi], ell_q[gi]} & {2{ch_en[gi]}}),
                .tov             (tov_q[gi]),
                .max_duty        (max_q[gi]),
                .pin_level       ((gi == 0) ? stable_q : 1'b0),
                .counter_value   (counter_value),
                .compare_value   (cmp_val[gi]),
                .overflow        (counter_overflow),
                .compare_inhibit (cmp_inh[gi]),
                .capture_inhibit (capblk_q[gi]),
                .capture_event   (cap_ev[gi]),
                .compare_event   (cmp_ev[gi]),
                .chan_out        (ch_out[gi]),
                .pin_drive       (ch_drive[gi])
            );
        end
    endgenerate

    always_comb
    begin
        sync_d = {sync_q[1:0], channel0_port_pin_in};
        // only the agreeing second and third stages move the stable level
        stable_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : stable_q;
        pready_d = psel && penable && !pready_q;
        pslverr_d = pready_d && !dec[3];
        rbyte = '0;
        case (dec[1:0])
            TCC_K_CTRL: rbyte = {flag_q[dec[2]], ie_q[dec[2]], buf_q[dec[2]], cmp_q[dec[2]],
                                 elh_q[dec[2]], ell_q[dec[2]], tov_q[dec[2]], max_q[dec[2]]};
            TCC_K_VALH: rbyte = value_q[dec[2]][CNT_W-1 -: BW];
            TCC_K_VALL: rbyte = value_q[dec[2]][BW-1:0];
            default:    rbyte = '0;
        endcase
        prdata_d = (pready_d && !pwrite) ? {24'h000000, rbyte} : prdata_q;
        ie_d = ie_q; buf_d = buf_q; cmp_d = cmp_q; elh_d = elh_q; ell_d = ell_q;
        tov_d = tov_q; max_d = max_q; flag_d = flag_q; arm_d = arm_q;
        capblk_d = capblk_q; cmpblk_d = cmpblk_q;
        sel_d = sel_q; swap_d = swap_q;
        for (int i = 0; i < NC; i++)
        begin
            value_d[i] = value_q[i];
            if (cap_ev[i])
                value_d[i] = counter_value;
            if (rd && dec[2] == 1'(i))
            begin
                if (dec[1:0] == TCC_K_CTRL && prdata_q[TCC_B_FLAG])
                    arm_d[i] = 1'b1;
                if (dec[1:0] == TCC_K_VALH && !buf_q[i] && !cmp_q[i])
                    capblk_d[i] = 1'b1;
                if (dec[1:0] == TCC_K_VALL)
                    capblk_d[i] = 1'b0;
            end
            if (wr && dec[2] == 1'(i))
            begin
                case (dec[1:0])
                    TCC_K_CTRL:
                    begin
                        if (ch_en[i])
                        begin
                            ie_d[i] = pwdata[TCC_B_IE];
                            buf_d[i] = pwdata[TCC_B_BUF];
                            cmp_d[i] = pwdata[TCC_B_CMP];
                            elh_d[i] = pwdata[TCC_B_ELH];
                            ell_d[i] = pwdata[TCC_B_ELL];
                            tov_d[i] = pwdata[TCC_B_TOV];
                            max_d[i] = pwdata[TCC_B_MAX];
                            if (arm_q[i] && !pwdata[TCC_B_FLAG])
                                flag_d[i] = 1'b0;
                        end
                        arm_d[i] = 1'b0;
                    end
                    TCC_K_VALH:
                    begin
                        value_d[i][CNT_W-1 -: BW] = pwdata[BW-1:0];
                        if (buf_q[i] || cmp_q[i] || (i == 1 && buf_q[0]))
                            cmpblk_d[i] = 1'b1;
                    end
                    TCC_K_VALL:
                    begin
                        value_d[i][BW-1:0] = pwdata[BW-1:0];
                        cmpblk_d[i] = 1'b0;
                        if (buf_q[0] && 1'(i) != sel_q)
                            swap_d = 1'b1;
                    end
                    default:
                        value_d[i] = value_q[i];
                endcase
            end
            // an event during the clearing sequence wins and cancels the pending clear
            if (cap_ev[i] || cmp_ev[i])
            begin
                flag_d[i] = 1'b1;
                arm_d[i] = 1'b0;
            end
            irq_d[i] = flag_q[i] && ie_q[i];
        end
        if (counter_overflow && swap_q)
        begin
            sel_d = !sel_q;
            swap_d = 1'b0;
        end
        if (!buf_q[0])
        begin
            sel_d = 1'b0;
            swap_d = 1'b0;
        end
        pin_out_d = ch_out[0];
        pin_oe_d = ch_drive[0];
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
            pin_out_q <= 1'b0;
            pin_oe_q <= 1'b0;
            irq_q <= '0;
            sync_q <= '0;
            stable_q <= 1'b0;
            {ie_q, buf_q, cmp_q} <= '0;
            {elh_q, ell_q} <= '0;
            {tov_q, max_q} <= '0;
            {flag_q, arm_q, capblk_q, cmpblk_q} <= '0;
            sel_q <= 1'b0;
            swap_q <= 1'b0;
        end
        else if (ce)
        begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
            pin_out_q <= pin_out_d;
            pin_oe_q <= pin_oe_d;
            irq_q <= irq_d;
            sync_q <= sync_d;
            stable_q <= stable_d;
            {ie_q, buf_q, cmp_q, elh_q, ell_q} <= {ie_d, buf_d, cmp_d, elh_d, ell_d};
            {tov_q, max_q, flag_q, arm_q} <= {tov_d, max_d, flag_d, arm_d};
            {capblk_q, cmpblk_q} <= {capblk_d, cmpblk_d};
            sel_q <= sel_d;
            swap_q <= swap_d;
        end
    end

    // value words are left without reset: their content after reset is undefined
    always_ff @(posedge clk)
    begin
        if (ce)
            value_q <= value_d;
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign channel0_port_pin_out = pin_out_q;
    assign channel0_port_pin_oe = pin_oe_q;
    assign channel_irq = irq_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // the default disable would swallow every attempt that starts in reset
    reset_detach_a: assert property (@(posedge clk) disable iff (1'b0) reset |=>
                                     (elh_q == '0 && ell_q == '0
                                                             && tov_q == '0))
        else $error("reset left edge select or toggle bits set");
    pin_detach_a: assert property (ce && !elh_q[0] && !ell_q[0] |=> !pin_oe_q)
        else $error("detached channel still drives the pin");
    cap_load_a: assert property (ce && cap_ev[0] && !wr |=> value_q[0] == $past(counter_value))
        else $error("capture did not load the counter value");
    cap_block_a: assert property (capblk_q[0] |-> !cap_ev[0])
        else $error("capture taken while high byte read is pending");
    cmp_block_a: assert property (cmpblk_q[1] |-> !cmp_ev[1])
        else $error("compare matched while high byte write is pending");
    flag_set_a: assert property (ce && (cap_ev[1] || cmp_ev[1]) |=> flag_q[1])
        else $error("channel event did not set the flag");
    ovf_toggle_a: assert property (ce && (buf_q[0] || cmp_q[0]) && tov_q[0] && counter_overflow
                                   && !(elh_q[0] && !ell_q[0]) && ch_en[0]
                                   |=> ch_out[0] != $past(ch_out[0]))
        else $error("overflow toggle lost to a compare action");
    buf_lock_a: assert property (ce && buf_q[0] && wr && dec[2] && dec[1:0] == TCC_K_CTRL
                                 |=> $stable(cmp_q[1]) && $stable(elh_q[1]))
        else $error("channel 1 control written during buffered mode");
    buf_swap_a: assert property (ce && !counter_overflow && buf_q[0] |=> $stable(sel_q))
        else $error("buffer switched away from an overflow");
    irq_level_a: assert property (ce && flag_q[0] && ie_q[0] |=> channel_irq[0])
        else $error("flagged enabled channel gave no request");

    cap_seen_c: cover property (cap_ev[0] ##[1:20] rd && dec[1:0] == TCC_K_VALL);
    cmp_seen_c: cover property (cmp_ev[0] && ch_drive[0]);
    swap_seen_c: cover property (counter_overflow && swap_q && buf_q[0]);
    flag_clear_c: cover property (flag_q[0] ##1 arm_q[0] ##[1:20] !flag_q[0]);
endmodule : tcc_top

// [verilog/tcc_pkg.sv]
// timer capture/compare channel pair: shared constants, mode type and decoders
// assumes an apb slave with 32-bit data, registers as bytes in the low lane
package tcc_pkg;
    localparam int        TCC_CNT_W      = 16;
    localparam int        TCC_BYTE_W     = 8;
    localparam int        TCC_NUM_CH     = 2;
    localparam int        TCC_ADDR_W     = 8;
    // register byte addresses, one aligned word each, channel 1 follows channel 0
    localparam logic [7:0] TCC_CTRL_OFF  = 8'h00;
    localparam logic [7:0] TCC_VALH_OFF  = 8'h04;
    localparam logic [7:0] TCC_VALL_OFF  = 8'h08;
    localparam logic [7:0] TCC_CH_STRIDE = 8'h0C;
    // control byte layout
    localparam int        TCC_B_FLAG     = 7;
    localparam int        TCC_B_IE       = 6;
    localparam int        TCC_B_BUF      = 5;
    localparam int        TCC_B_CMP      = 4;
    localparam int        TCC_B_ELH      = 3;
    localparam int        TCC_B_ELL      = 2;
    localparam int        TCC_B_TOV      = 1;
    localparam int        TCC_B_MAX      = 0;
    localparam logic [1:0] TCC_K_CTRL    = 2'h0;
    localparam logic [1:0] TCC_K_VALH    = 2'h1;
    localparam logic [1:0] TCC_K_VALL    = 2'h2;
    localparam logic [1:0] TCC_EL_OFF    = 2'h0;
    localparam logic [1:0] TCC_EL_TOGGLE = 2'h1;
    localparam logic [1:0] TCC_EL_CLEAR  = 2'h2;
    localparam logic [1:0] TCC_EL_SET    = 2'h3;
    localparam logic [7:0] TCC_CTRL_RST  = 8'h00;

    typedef enum logic [2:0] {
        TCC_PRESET  = 3'b001,
        TCC_CAPTURE = 3'b010,
        TCC_COMPARE = 3'b100
    } tcc_mode_type;

    function automatic tcc_mode_type tcc_decode_mode(input logic buf_sel, input logic cmp_sel,
                                                     input logic [1:0] els);
        tcc_mode_type m;
        if (buf_sel || cmp_sel)
            m = TCC_COMPARE;
        else if (els == TCC_EL_OFF)
            m = TCC_PRESET;
        else
            m = TCC_CAPTURE;
        return m;
    endfunction : tcc_decode_mode

    // returns {valid, channel, kind}
    function automatic logic [3:0] tcc_decode_addr(input logic [7:0] addr);
        logic [3:0] r;
        logic [7:0] rel;
        r = 4'h0;
        rel = (addr >= TCC_CH_STRIDE) ? 8'(addr - TCC_CH_STRIDE) : addr;
        if (addr < 8'(2 * TCC_CH_STRIDE))
        begin
            r[2] = (addr >= TCC_CH_STRIDE);
            if (rel == TCC_CTRL_OFF)
                r = {1'b1, r[2], TCC_K_CTRL};
            else if (rel == TCC_VALH_OFF)
                r = {1'b1, r[2], TCC_K_VALH};
            else if (rel == TCC_VALL_OFF)
                r = {1'b1, r[2], TCC_K_VALL};
        end
        return r;
    endfunction : tcc_decode_addr
endpackage : tcc_pkg

// [verilog/tcc_channel.sv]
// one timer channel: mode decode, capture edge detect, compare match, output level
// assumes counter, overflow pulse and pin level are already in the clk domain
module tcc_channel
    import tcc_pkg::*;
#(
    parameter int CNT_W = tcc_pkg::TCC_CNT_W
)
(
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             ce,
    input  wire logic             buf_sel,
    input  wire logic             cmp_sel,
    input  wire logic [1:0]       els,
    input  wire logic             tov,
    input  wire logic             max_duty,
    input  wire logic             pin_level,
    input  wire logic [CNT_W-1:0] counter_value,
    input  wire logic [CNT_W-1:0] compare_value,
    input  wire logic             overflow,
    input  wire logic             compare_inhibit,
    input  wire logic             capture_inhibit,
    output logic                  capture_event,
    output logic                  compare_event,
    output logic                  chan_out,
    output logic                  pin_drive
);
    tcc_mode_type mode;
    logic         prev_q, prev_d;
    logic         out_q, out_d;
    logic         max_eff_q, max_eff_d;
    logic         rise, fall, force_high;

    always_comb
    begin
        mode = tcc_decode_mode(buf_sel, cmp_sel, els);
        rise = pin_level && !prev_q;
        fall = !pin_level && prev_q;
        capture_event = 1'b0;
        compare_event = 1'b0;
        prev_d = pin_level;
        max_eff_d = overflow ? max_duty : max_eff_q;
        force_high = max_eff_q && tov && (els == TCC_EL_CLEAR);
        out_d = out_q;
        case (mode)
            TCC_PRESET:
                out_d = !cmp_sel;
            TCC_CAPTURE:
            begin
                capture_event = !capture_inhibit && ((els[0] && rise) || (els[1] && fall));
            end
            TCC_COMPARE:
            begin
                compare_event = !compare_inhibit && (counter_value == compare_value);
                if (overflow && tov)
                    out_d = !out_q;
                else if (compare_event)
                begin
                    case (els)
                        TCC_EL_TOGGLE: out_d = !out_q;
                        TCC_EL_CLEAR:  out_d = 1'b0;
                        TCC_EL_SET:    out_d = 1'b1;
                        default:       out_d = out_q;
                    endcase
                end
                if (force_high)
                    out_d = 1'b1;
                else if ((els == TCC_EL_CLEAR) && !tov && !max_eff_q)
                    out_d = 1'b0;
            end
            default:
                out_d = out_q;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            prev_q <= 1'b0;
            out_q <= 1'b0;
            max_eff_q <= 1'b0;
        end
        else if (ce)
        begin
            prev_q <= prev_d;
            out_q <= out_d;
            max_eff_q <= max_eff_d;
        end
    end

    assign chan_out = out_q;
    assign pin_drive = (els != TCC_EL_OFF) && (mode == TCC_COMPARE);

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    full_duty_a: assert property (ce && mode == TCC_COMPARE && force_high |=> out_q)
        else $error("forced full duty did not hold the output high");
    zero_duty_a: assert property (ce && mode == TCC_COMPARE && els == TCC_EL_CLEAR && !tov
                                  && !max_eff_q |=> !out_q)
        else $error("zero duty setting left the output high");
    max_latency_a: assert property (ce && !overflow |=> $stable(max_eff_q))
        else $error("max duty changed away from a period boundary");
    cap_edge_a: assert property (capture_event |-> mode == TCC_CAPTURE &&
                                 ((els[0] && rise) || (els[1] && fall)))
        else $error("capture without a selected edge");
endmodule : tcc_channel

// [sim/tcc_pin_model.sv]
// outside source on the channel 0 pin
// assumes the bench picks the level it drives while the channel lets go
module tcc_pin_model
(
    input  wire logic pin_out,
    input  wire logic pin_oe,
    input  wire logic ext_level,
    output logic      pin_level
);
    timeunit 1ns;
    timeprecision 1ns;
    // the device owns the wire only while enabled
    assign pin_level = pin_oe ? pin_out : ext_level;
endmodule : tcc_pin_model

// [sim/tb_top.sv]
// self-checking bench for the two-channel capture/compare block
// assumes the bench itself plays counter, overflow source and apb master
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import tcc_pkg::*;
    logic        clk, reset, ce, psel, penable, pwrite, ovf, ext, pin, pout, poe;
    logic        pready, pslverr, e, b;
    logic [7:0]  paddr, r;
    logic [31:0] pwdata, prdata;
    logic [15:0] cnt;
    logic [1:0]  irq;
    int          failures, check_count;
    int          cyc = 0;

    tcc_top tcc_top_i (.clk(clk), .reset(reset), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .counter_value(cnt), .counter_overflow(ovf),
        .channel0_port_pin_in(pin), .channel0_port_pin_out(pout),
        .channel0_port_pin_oe(poe), .channel_irq(irq));
    tcc_pin_model tcc_pin_model_i (.pin_out(pout), .pin_oe(poe), .ext_level(ext),
        .pin_level(pin));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task summarize;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    // a hung handshake must still reach the verdict
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            failures++;
            summarize;
        end
    end

    task cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : cmp

    // opens with an edge so a following transfer never reassigns in one step
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // only the cycle ceiling ends a wait that never sees pready
        while (pready !== 1'b1)
            @(posedge clk);
        r = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // one cycle of counter value and overflow, then idle away from any match
    task pulse(input logic ov, input logic [15:0] cv);
        @(posedge clk);
        ovf <= ov;
        cnt <= cv;
        @(posedge clk);
        ovf <= 1'b0;
        cnt <= 16'hFFFF;
        repeat (3) @(posedge clk);
    endtask : pulse

    task t_reset;
        apb(0, 8'h00, 8'h00);
        cmp(r, 16'h0, "ctrl0 reset");
        apb(0, 8'h0C, 8'h00);
        cmp(r, 16'h0, "ctrl1 reset");
        apb(1, 8'h0C, 8'h00);
        cmp(poe, 16'h0, "pin released");
        apb(0, 8'h40, 8'h00);
        cmp(e, 16'h1, "unmapped error");
        $display("t_reset done");
    endtask : t_reset

    task t_compare;
        apb(1, 8'h04, 8'h00);
        apb(1, 8'h08, 8'h20);
        apb(1, 8'h00, 8'h14);
        repeat (2) @(posedge clk);
        cmp(poe, 16'h1, "pin driven");
        b = pout;
        pulse(0, 16'h0020);
        cmp(pout, !b, "toggle on match");
        apb(0, 8'h00, 8'h00);
        cmp(r[7], 16'h1, "flag set");
        apb(1, 8'h00, 8'h14);
        apb(0, 8'h00, 8'h00);
        cmp(r[7], 16'h0, "flag cleared");
        apb(1, 8'h04, 8'h00);
        pulse(0, 16'h0020);
        cmp(pout, !b, "match held off");
        apb(1, 8'h08, 8'h20);
        pulse(0, 16'h0020);
        cmp(pout, b, "match after low");
        $display("t_compare done");
    endtask : t_compare

    task t_overflow;
        apb(1, 8'h00, 8'h1A);
        repeat (2) @(posedge clk);
        b = pout;
        pulse(1, 16'hFFFF);
        cmp(pout, !b, "overflow toggle");
        if (pout === 1'b1)
            pulse(1, 16'hFFFF);
        pulse(1, 16'h0020);
        cmp(pout, 16'h1, "overflow wins");
        apb(1, 8'h00, 8'h1B);
        pulse(0, 16'h0020);
        cmp(pout, 16'h0, "max waits period");
        pulse(1, 16'hFFFF);
        pulse(0, 16'h0020);
        cmp(pout, 16'h1, "max duty high");
        apb(1, 8'h00, 8'h18);
        pulse(1, 16'hFFFF);
        pulse(0, 16'h0020);
        cmp(pout, 16'h0, "zero duty");
        apb(1, 8'h00, 8'h30);
        apb(1, 8'h0C, 8'h14);
        apb(0, 8'h0C, 8'h00);
        cmp(r, 16'h0, "ch1 ctrl locked");
        $display("t_overflow done");
    endtask : t_overflow

    task t_capture;
        apb(1, 8'h00, 8'h00);
        ext <= 1'b0;
        repeat (4) @(posedge clk);
        apb(1, 8'h00, 8'h44);
        cnt <= 16'h1234;
        ext <= 1'b1;
        repeat (8) @(posedge clk);
        apb(0, 8'h04, 8'h00);
        cmp(r, 16'h12, "capture high");
        cnt <= 16'h5678;
        ext <= 1'b0;
        repeat (8) @(posedge clk);
        ext <= 1'b1;
        repeat (8) @(posedge clk);
        apb(0, 8'h08, 8'h00);
        cmp(r, 16'h34, "capture blocked");
        apb(0, 8'h00, 8'h00);
        cmp(r[7], 16'h1, "capture flag");
        cmp(irq[0], 16'h1, "irq level");
        $display("t_capture done");
    endtask : t_capture

    initial
    begin
        reset = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cnt = 16'hFFFF;
        ovf = 1'b0;
        ext = 1'b0;
        failures = 0;
        check_count = 0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        t_reset;
        t_compare;
        t_overflow;
        t_capture;
        summarize;
    end
endmodule : tb_top
